// file: rtl/dmc_pkg.sv
// Purpose: Shared constants and types for the display memory cycle timer.
// Assumes: One fast clock; two clock periods make one controller clock period.
// Notes: Memory cycle lengths are counted in controller clocks.
package dmc_pkg;

  localparam int AD_W = 16;
  localparam int ADDR_W = 18;
  localparam int REF_W = 8;
  localparam int ZOOM_W = 4;
  localparam int CNT_W = 6;

  localparam logic [CNT_W-1:0] FIRST_CLOCK = 6'h01;
  localparam logic [CNT_W-1:0] LOAD_CLOCK = 6'h02;
  localparam logic [CNT_W-1:0] BASE_CLOCKS = 6'h02;
  localparam logic [CNT_W-1:0] RMW_CLOCKS = 6'h04;
  localparam logic [CNT_W-1:0] RMW_READ_CLOCK = 6'h03;

  localparam logic [REF_W-1:0] REF_RESET = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 18'h00000;
  localparam logic [AD_W-REF_W-1:0] REF_PAD = 8'h00;

  // Request kinds offered by the cycle arbiter.
  typedef enum logic [1:0] {
    REQ_DISPLAY,
    REQ_RMW,
    REQ_RETRACE
  } dmc_req_kind_t;

  // Memory cycle currently on the bus.
  typedef enum logic [2:0] {
    MC_IDLE,
    MC_DISPLAY,
    MC_RMW,
    MC_REFRESH,
    MC_RETRACE
  } dmc_cycle_t;

  // One memory cycle request; zoom_m1 is the zoom factor minus one.
  typedef struct packed {
    dmc_req_kind_t kind;
    logic [ADDR_W-1:0] addr;
    logic [ZOOM_W-1:0] zoom_m1;
  } dmc_req_t;

  // Registered pin image.
  typedef struct packed {
    logic ctrl_clk;
    logic ale;
    logic [AD_W-1:0] ad;
    logic ad_oe;
    logic upper_low;
    logic upper_high;
    logic read_en_n;
    logic active;
  } dmc_pins_t;

endpackage : dmc_pkg

// file: rtl/dmc_cycle_timer.sv
// Purpose: Frames display memory cycles on the multiplexed address/data bus.
// Assumes: Requests come from logic on CLK_I; every controller clock is two CLK_I periods.
// Notes: The first half of each controller clock is its high phase.
`timescale 1ns/1ps

// Summary of operation
// - Memory cycles last an even number of clocks.
// - Clocks begin on rising edge, numbered from one.
// - Strobe high first half, falls mid clock one.
// - Strobe high half a clock before falling.
// - Address driven and steady through clock one.
// - Upper address changes only at clock one.
// - Bus floats after clock one, every cycle type.
// - Only blanking gives a cycle-type hint before middle of clock two.
// - Refresh cycles emit 8-bit refresh counter values.
// - Strobe as row strobe only if precharge met.
// - Display cycle raises strobe at end of two.
// - Zoom adds two clocks per increment, strobe high.
// - Strobe low at falling edge of load clocks.
// - Non-display loads are blanked by the device.
// - Refresh on low eight lines, enabled by command.
// - Blanking output marks active display cycles.
module dmc_cycle_timer (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire dmc_pkg::dmc_req_t REQ_I,
  input wire logic REQ_VALID_I,
  output logic REQ_READY_O,
  input wire logic RETRACE_I,
  input wire logic REFRESH_EN_I,
  output logic CONTROLLER_CLOCK_O,
  output logic ALE_O,
  output logic [dmc_pkg::AD_W-1:0] MUXED_ADDR_DATA_BUS_O,
  output logic MUXED_ADDR_DATA_BUS_OE_O,
  output logic UPPER_ADDRESS_LOW_PIN_O,
  output logic UPPER_ADDRESS_HIGH_PIN_O,
  output logic READ_DATA_ENABLE_N_O,
  output logic BLANKING_O
);
  import dmc_pkg::*;

  logic half;
  logic next_half;
  logic [CNT_W-1:0] clk_no;
  logic [CNT_W-1:0] next_clk_no;
  logic [CNT_W-1:0] len;
  logic [CNT_W-1:0] next_len;
  dmc_cycle_t kind;
  dmc_cycle_t next_kind;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] next_addr;
  logic [REF_W-1:0] ref_cnt;
  logic [REF_W-1:0] next_ref_cnt;
  logic ready;
  logic next_ready;
  dmc_pins_t pins;
  dmc_pins_t next_pins;
  logic cycle_end;

  // Pin image for a given position inside a memory cycle.
  function automatic dmc_pins_t pins_of(input logic h, input logic [CNT_W-1:0] n,
                                        input dmc_cycle_t k, input logic [ADDR_W-1:0] a,
                                        input logic [REF_W-1:0] r);
    dmc_pins_t p;
    p.ctrl_clk = !h;
    // Low from mid clock one; display-like cycles raise it after clock two.
    p.ale = (k == MC_IDLE) || (n == FIRST_CLOCK && !h)
      || (k != MC_RMW && n > LOAD_CLOCK);
    p.ad_oe = (k != MC_IDLE) && (n == FIRST_CLOCK);
    if (!p.ad_oe) begin
      p.ad = '0;
    end else if (k == MC_REFRESH) begin
      p.ad = {REF_PAD, r};
    end else begin
      p.ad = a[AD_W-1:0];
    end
    p.upper_low = a[AD_W];
    p.upper_high = a[AD_W+1];
    // Read enable only after clock two, so it shows no type hint early.
    p.read_en_n = !(k == MC_RMW && n == RMW_READ_CLOCK);
    p.active = (k == MC_DISPLAY);
    return p;
  endfunction : pins_of

  // Length in controller clocks; always even.
  function automatic logic [CNT_W-1:0] len_of(input dmc_cycle_t k,
                                              input logic [ZOOM_W-1:0] z);
    logic [CNT_W-1:0] l;
    case (k)
      MC_DISPLAY: l = CNT_W'({z, 1'b0}) + BASE_CLOCKS;
      MC_RMW: l = RMW_CLOCKS;
      default: l = BASE_CLOCKS;
    endcase
    return l;
  endfunction : len_of

  assign cycle_end = half && (clk_no == len);

  always_comb begin
    next_half = !half;
    next_clk_no = clk_no;
    next_len = len;
    next_kind = kind;
    next_addr = addr;
    next_ref_cnt = ref_cnt;
    if (half) begin
      next_clk_no = clk_no + FIRST_CLOCK;
    end
    if (cycle_end) begin
      next_clk_no = FIRST_CLOCK;
      if (kind == MC_REFRESH) begin
        next_ref_cnt = ref_cnt + 8'h01;
      end
      // Retrace slots become refresh cycles only when enabled.
      if (RETRACE_I && REFRESH_EN_I
          && !(REQ_VALID_I && REQ_I.kind != REQ_RETRACE)) begin
        next_kind = MC_REFRESH;
      end else if (REQ_VALID_I) begin
        case (REQ_I.kind)
          REQ_DISPLAY: next_kind = MC_DISPLAY;
          REQ_RMW: next_kind = MC_RMW;
          default: next_kind = MC_RETRACE;
        endcase
        next_addr = REQ_I.addr;
      end else begin
        next_kind = MC_IDLE;
      end
      next_len = len_of(next_kind, REQ_I.zoom_m1);
    end
    next_ready = next_half && (next_clk_no == next_len);
    next_pins = pins_of(next_half, next_clk_no, next_kind, next_addr, next_ref_cnt);
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      half <= 1'b1;
      clk_no <= BASE_CLOCKS;
      len <= BASE_CLOCKS;
      kind <= MC_IDLE;
      addr <= ADDR_RESET;
      ref_cnt <= REF_RESET;
      ready <= 1'b1;
      pins <= '{ctrl_clk: 1'b0, ale: 1'b1, ad: '0, ad_oe: 1'b0, upper_low: 1'b0,
                upper_high: 1'b0, read_en_n: 1'b1, active: 1'b0};
    end else begin
      half <= next_half;
      clk_no <= next_clk_no;
      len <= next_len;
      kind <= next_kind;
      addr <= next_addr;
      ref_cnt <= next_ref_cnt;
      ready <= next_ready;
      pins <= next_pins;
    end
  end

  assign REQ_READY_O = ready;
  assign CONTROLLER_CLOCK_O = pins.ctrl_clk;
  assign ALE_O = pins.ale;
  assign MUXED_ADDR_DATA_BUS_O = pins.ad;
  assign MUXED_ADDR_DATA_BUS_OE_O = pins.ad_oe;
  assign UPPER_ADDRESS_LOW_PIN_O = pins.upper_low;
  assign UPPER_ADDRESS_HIGH_PIN_O = pins.upper_high;
  assign READ_DATA_ENABLE_N_O = pins.read_en_n;
  assign BLANKING_O = pins.active;

  default clocking dmc_cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  logic cyc_start;
  assign cyc_start = !half && (clk_no == FIRST_CLOCK) && (kind != MC_IDLE);

  sequence s_start;
    cyc_start;
  endsequence

  sequence s_display_start;
    cyc_start && kind == MC_DISPLAY;
  endsequence

  sequence s_addr_phase;
    MUXED_ADDR_DATA_BUS_OE_O ##1 MUXED_ADDR_DATA_BUS_OE_O && $stable(MUXED_ADDR_DATA_BUS_O);
  endsequence

  sequence s_strobe_frame;
    ALE_O ##1 !ALE_O;
  endsequence

  AST_EVEN_LENGTH: assert property (s_start |-> len[0] == 1'b0)
    else $error("Memory cycle length is odd.");

  AST_CLOCK_ONE_RISES: assert property (s_start |-> $rose(CONTROLLER_CLOCK_O))
    else $error("Clock one did not begin on a rising controller clock edge.");

  AST_STROBE_FALLS_MID_ONE: assert property (s_start |-> s_strobe_frame)
    else $error("Address strobe did not fall at the middle of clock one.");

  AST_STROBE_HIGH_BEFORE_FALL: assert property (
    $fell(ALE_O) |-> $past(ALE_O) && $past(CONTROLLER_CLOCK_O) && !CONTROLLER_CLOCK_O)
    else $error("Address strobe fell without a half clock high phase.");

  AST_ADDRESS_HELD: assert property (s_start |-> s_addr_phase)
    else $error("Address not held steady through clock one.");

  AST_BUS_FLOATS: assert property (s_start |-> ##2 !MUXED_ADDR_DATA_BUS_OE_O [*2])
    else $error("Multiplexed bus still driven after clock one.");

  AST_UPPER_ONLY_AT_START: assert property (
    $changed({UPPER_ADDRESS_HIGH_PIN_O, UPPER_ADDRESS_LOW_PIN_O}) |-> cyc_start)
    else $error("Upper address changed outside the start of clock one.");

  AST_NO_EARLY_HINT: assert property (
    s_start |-> ##1 (!ALE_O && READ_DATA_ENABLE_N_O) [*3])
    else $error("Cycle type visible before the middle of clock two.");

  AST_LOAD_CLOCK_LOW: assert property (
    s_start |-> ##3 (!ALE_O && !CONTROLLER_CLOCK_O))
    else $error("Address strobe not low at the falling edge of clock two.");

  AST_DISPLAY_RAISES: assert property (s_display_start |-> ##4 ALE_O)
    else $error("Display cycle did not raise the strobe after clock two.");

  AST_ZOOM_LENGTH: assert property (
    s_display_start |-> len == CNT_W'({$past(REQ_I.zoom_m1), 1'b0}) + BASE_CLOCKS)
    else $error("Zoomed display cycle has the wrong length.");

  AST_ZOOM_STROBE_HIGH: assert property (
    kind == MC_DISPLAY && clk_no > LOAD_CLOCK |-> ALE_O)
    else $error("Strobe low during zoom extension clocks.");

  AST_REFRESH_ADDRESS: assert property (
    kind == MC_REFRESH && MUXED_ADDR_DATA_BUS_OE_O
    |-> MUXED_ADDR_DATA_BUS_O == {REF_PAD, ref_cnt})
    else $error("Refresh cycle did not drive the refresh counter.");

  AST_REFRESH_ENABLED: assert property (
    s_start and (kind == MC_REFRESH) |-> $past(REFRESH_EN_I) && $past(RETRACE_I))
    else $error("Refresh cycle ran without enable or outside retrace.");

  AST_REFRESH_ADVANCES: assert property (
    kind == MC_REFRESH && cycle_end |=> ref_cnt == $past(ref_cnt) + 8'h01)
    else $error("Refresh counter did not advance after a refresh cycle.");

  AST_BLANK_NON_DISPLAY: assert property (BLANKING_O |-> kind == MC_DISPLAY)
    else $error("Non-display cycle shown as active display.");

  AST_BLANK_MARKS_DISPLAY: assert property (s_display_start |-> BLANKING_O [*2])
    else $error("Active display cycle not marked on the blanking output.");

endmodule : dmc_cycle_timer

// file: tb/dmc_dram_model.sv
// Purpose: Far-side model of the strobe and video load logic of a display memory.
// Assumes: Strobe and controller clock are registered on CLK_I rising edges.
// Notes: The strobe is sampled as it stands when the controller clock falls.
`timescale 1ns/1ps
module dmc_dram_model (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ctrl_clk_i,
  input wire logic ale_i,
  input wire logic [dmc_pkg::AD_W-1:0] ad_i,
  input wire logic [1:0] upper_i,
  output logic [17:0] row_addr_o,
  output logic [7:0] loads_o
);
  logic ale_last;
  logic ale_at_fall;
  logic [2:0] pix;
  logic [1:0] ale_dly;
  logic ras_n;
  logic cas_n;
  // Row and column strobes follow the address strobe through a CLK_I-rate delay line.
  assign ras_n = ale_dly[0];
  // Column strobe needs the strobe low now and two fast clocks back, so refresh slots show it too.
  assign cas_n = ale_dly[1] || ale_i;
  // Reset sets the strobe sample high so loads start aligned.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ale_last <= 1'b1;
      ale_at_fall <= 1'b1;
      pix <= 3'h4;
      ale_dly <= 2'h3;
      loads_o <= 8'h00;
      row_addr_o <= 18'h00000;
    end else begin
      ale_last <= ale_i;
      // Eight pixels make one controller clock, four per fast clock period.
      pix <= pix + 3'h4;
      ale_dly <= {ale_dly[0], ale_i};
      if (ale_last && !ale_i) begin
        row_addr_o <= {upper_i, ad_i};
      end
      if (ctrl_clk_i) begin
        ale_at_fall <= ale_i;
      end else if (!ale_at_fall && &(pix + 3'h3) && !cas_n) begin
        loads_o <= loads_o + 8'h01;
      end
    end
  end
endmodule : dmc_dram_model

// file: tb/dmc_cycle_timer_bench.sv
// Purpose: Self-checking bench for the display memory cycle timer.
// Assumes: Inputs change 5 ns after each rising CLK_I edge.
// Notes: Each scenario walks two memory cycles (test_rmw one) clock by clock.
`timescale 1ns/1ps
module dmc_cycle_timer_bench;
  import dmc_pkg::*;
  logic CLK_I = 1'b0;
  logic RST_N_I, REQ_VALID_I, RETRACE_I, REFRESH_EN_I, REQ_READY_O, CONTROLLER_CLOCK_O, ALE_O;
  logic OE, UP_LO, UP_HI, RD_N, BLANK;
  dmc_req_t REQ_I;
  logic [AD_W-1:0] AD;
  logic [17:0] row_addr;
  logic [7:0] loads;
  logic [7:0] ref_cnt = 8'h00;
  int mismatches = 0;
  int checks_done = 0;
  always #25 CLK_I = ~CLK_I;
  dmc_cycle_timer u_dut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .REQ_I(REQ_I),
    .REQ_VALID_I(REQ_VALID_I), .REQ_READY_O(REQ_READY_O), .RETRACE_I(RETRACE_I),
    .REFRESH_EN_I(REFRESH_EN_I), .CONTROLLER_CLOCK_O(CONTROLLER_CLOCK_O), .ALE_O(ALE_O),
    .MUXED_ADDR_DATA_BUS_O(AD), .MUXED_ADDR_DATA_BUS_OE_O(OE),
    .UPPER_ADDRESS_LOW_PIN_O(UP_LO), .UPPER_ADDRESS_HIGH_PIN_O(UP_HI),
    .READ_DATA_ENABLE_N_O(RD_N), .BLANKING_O(BLANK));
  dmc_dram_model u_mem (.clk_i(CLK_I), .rst_n_i(RST_N_I), .ctrl_clk_i(CONTROLLER_CLOCK_O),
    .ale_i(ALE_O), .ad_i(AD), .upper_i({UP_HI, UP_LO}), .row_addr_o(row_addr),
    .loads_o(loads));
  task automatic check(input logic [17:0] seen, input logic [17:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : check
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  // Offers one request (or a refresh slot) and checks every clock of the cycle.
  task automatic run_cycle(input dmc_req_kind_t kind, input logic [17:0] addr,
                           input logic [3:0] zm1, input logic refr);
    int n;
    int low_end;
    int i;
    logic [7:0] loads0;
    logic [15:0] ad_exp;
    logic rmw;
    logic disp;
    rmw = !refr && kind == REQ_RMW;
    disp = !refr && kind == REQ_DISPLAY;
    n = rmw ? 8 : (disp ? 4 * (zm1 + 1) : 4);
    low_end = rmw ? 8 : 4;
    ad_exp = refr ? {REF_PAD, ref_cnt} : addr[15:0];
    i = 0;
    while (REQ_READY_O !== 1'b1 && i < 60) begin
      @(posedge CLK_I);
      #5;
      i++;
    end
    check(REQ_READY_O, 1'b1, "ready before request");
    REQ_I = '{kind, addr, zm1};
    REQ_VALID_I = !refr;
    RETRACE_I = refr;
    loads0 = loads;
    @(posedge CLK_I);
    #5;
    REQ_VALID_I = 1'b0;
    RETRACE_I = 1'b0;
    for (i = 1; i <= n; i++) begin
      check(CONTROLLER_CLOCK_O, i % 2, "controller clock phase");
      check(ALE_O, (i == 1) || (i > low_end), "strobe level");
      check(OE, i <= 2, "bus drive enable");
      check(AD, (i <= 2) ? ad_exp : 16'h0000, "bus value");
      check(RD_N, !(rmw && (i == 5 || i == 6)), "read enable");
      check(BLANK, disp, "blanking");
      if (!refr) begin
        check({UP_HI, UP_LO}, addr[17:16], "upper address");
      end
      check(REQ_READY_O, i == n, "cycle end");
      if (i < n) begin
        @(posedge CLK_I);
        #5;
      end
    end
    @(posedge CLK_I);
    #5;
    check(loads - loads0, rmw ? 8'h03 : 8'h01, "video loads");
    if (!refr) begin
      check(row_addr, addr, "latched address");
    end else begin
      ref_cnt = ref_cnt + 8'h01;
    end
  endtask : run_cycle
  task automatic test_display;
    run_cycle(REQ_DISPLAY, 18'h3a5c3, 4'h0, 1'b0);
    run_cycle(REQ_DISPLAY, 18'h1ffff, 4'h0, 1'b0);
    $display("test_display done");
  endtask : test_display
  task automatic test_zoom;
    run_cycle(REQ_DISPLAY, 18'h2c0de, 4'h1, 1'b0);
    run_cycle(REQ_DISPLAY, 18'h00001, 4'h2, 1'b0);
    $display("test_zoom done");
  endtask : test_zoom
  task automatic test_rmw;
    run_cycle(REQ_RMW, 18'h15a5a, 4'h0, 1'b0);
    $display("test_rmw done");
  endtask : test_rmw
  task automatic test_refresh;
    run_cycle(REQ_DISPLAY, 18'h00000, 4'h0, 1'b1);
    run_cycle(REQ_DISPLAY, 18'h00000, 4'h0, 1'b1);
    $display("test_refresh done");
  endtask : test_refresh
  initial begin
    RST_N_I = 1'b0;
    REQ_VALID_I = 1'b0;
    RETRACE_I = 1'b0;
    REFRESH_EN_I = 1'b1;
    REQ_I = '0;
    repeat (12) @(posedge CLK_I);
    #5;
    check({REQ_READY_O, ALE_O, OE, BLANK, RD_N}, 5'h19, "reset state");
    RST_N_I = 1'b1;
    test_display();
    test_zoom();
    test_rmw();
    test_refresh();
    print_verdict();
  end
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
endmodule : dmc_cycle_timer_bench
